// [tbr_defs.vh]
// Constants shared by the bus role configuration block
`ifndef TBR_DEFS_VH
`define TBR_DEFS_VH

// ****************************************************************
// Role strap codes
// ****************************************************************
`define TBR_ROLE_MAIN 3'h0
`define TBR_ROLE_SEC 3'h1
`define TBR_ROLE_SDR_MAIN 3'h2
`define TBR_ROLE_SDR_SEC 3'h3
`define TBR_ROLE_TGT 3'h4
`define TBR_ROLE_SDR_TGT 3'h5

// ****************************************************************
// Bus traits byte layout and codes
// ****************************************************************
`define TBR_BT_ROLE_HI 7
`define TBR_BT_ROLE_LO 6
`define TBR_BT_HDR 5
`define TBR_BT_BRIDGE 4
`define TBR_BT_OFFLINE 3
`define TBR_BT_ROLE_TGT 2'h0
`define TBR_BT_ROLE_CTRL 2'h1
`define TBR_BT_RESET 8'h00

// ****************************************************************
// Addressing
// ****************************************************************
`define TBR_DYN_ADDR_BASE 7'h08
`define TBR_ADDR_BCAST 7'h7E
`define TBR_ADDR_RESET 7'h00

// ****************************************************************
// Exit pattern timing
// ****************************************************************
`define TBR_EXIT_FALLS 4'h4
`define TBR_CLK_NS 20
`define TBR_EXIT_HALF_NS 100
`define TBR_EXIT_HALF_CYC ((`TBR_EXIT_HALF_NS + `TBR_CLK_NS - 1) / `TBR_CLK_NS)

`endif

// [tbr_exit_pattern.v]
// High-rate exit pattern detector and generator on the two bus pins
`timescale 1ns/10ps
`include "tbr_defs.vh"

module tbr_exit_pattern
(
  input wire clk,
  input wire reset,
  input wire sda_in,
  input wire scl_in,
  input wire gen_req,
  output reg sda_out,
  output reg sda_oe_n,
  output reg scl_out,
  output reg scl_oe_n,
  output reg exit_seen,
  output wire gen_busy
);

  localparam integer HALF_INT = `TBR_EXIT_HALF_CYC;
  localparam [7:0] HALF_CYC = HALF_INT[7:0];

  // ****************************************************************
  // Pin synchronisers and filtered levels
  // ****************************************************************
  reg [2:0] sda_sync;
  reg [2:0] scl_sync;
  reg sda_f;
  reg scl_f;
  reg [3:0] fall_cnt;

  always @(posedge clk)
  begin
    if (reset)
    begin
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
      sda_f <= 1'b1;
      scl_f <= 1'b1;
      fall_cnt <= 4'h0;
      exit_seen <= 1'b0;
    end
    else
    begin
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
      exit_seen <= 1'b0;
      if (sda_sync[1] == sda_sync[2])
        sda_f <= sda_sync[2];
      if (scl_sync[1] == scl_sync[2])
        scl_f <= scl_sync[2];
      // Falls only count while the clock line is held low
      if (scl_f)
        fall_cnt <= 4'h0;
      else if (sda_f && !sda_sync[1] && !sda_sync[2])
      begin
        if (fall_cnt == `TBR_EXIT_FALLS - 4'h1)
        begin
          fall_cnt <= 4'h0;
          exit_seen <= 1'b1;
        end
        else
          fall_cnt <= fall_cnt + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Generator: clock held low, data pulled low four times
  // ****************************************************************
  reg [7:0] tick_cnt;
  reg [3:0] phase;
  reg active;

  assign gen_busy = active;

  always @(posedge clk)
  begin
    if (reset)
    begin
      tick_cnt <= 8'h00;
      phase <= 4'h0;
      active <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
    end
    else if (!active)
    begin
      if (gen_req)
      begin
        active <= 1'b1;
        phase <= 4'h0;
        tick_cnt <= 8'h00;
        scl_oe_n <= 1'b0;
        sda_oe_n <= 1'b1;
      end
    end
    else if (tick_cnt == HALF_CYC - 8'h01)
    begin
      tick_cnt <= 8'h00;
      phase <= phase + 4'h1;
      if (phase == (`TBR_EXIT_FALLS << 1))
      begin
        // Release both lines; pull-ups restore idle
        active <= 1'b0;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
      end
      else
        sda_oe_n <= phase[0];
    end
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

endmodule // tbr_exit_pattern

// [tbr_role_config.v]
// Role-dependent bus configuration, address assignment and capabilities
`timescale 1ns/10ps
`include "tbr_defs.vh"

// What this block does
// - Bring-up happens only in single-rate mode
// - Single-rate mode is default; high-rate entered from it
// - Main controller assigns unique addresses, itself included
// - Lower dynamic address wins interrupt arbitration
// - Share addresses and traits with secondary controllers
// - Enabled features reported in traits register
// - Legacy devices known before bring-up starts
// - Targets ignore legacy two-wire traffic
// - Each role performs all its matrix duties
// - Only controllers manage data-line arbitration
// - Only main controllers assign addresses at start-up
// - Hot-join assignment: main yes, secondary optional
// - Full-capability roles accept high-rate access
// - Full-capability controllers may drive high-rate transfers
// - Every controller can generate the exit pattern
// - Every target detects the exit pattern
// - Traits top bits: 00 target, 01 controller
module tbr_role_config
#(
  parameter MAX_DEV = 8,
  parameter SW = 3,
  parameter BRIDGE = 1'b0,
  parameter OFFLINE = 1'b0,
  parameter [2:0] LOW_TRAITS = 3'h0
)
(
  input wire clk,
  input wire reset,
  input wire [2:0] role_strap,
  input wire hj_assign_en,
  input wire bus_start,
  input wire legacy_known,
  input wire [6:0] legacy_addr,
  input wire [MAX_DEV-1:0] dev_present,
  input wire sec_present,
  output wire assign_valid,
  input wire assign_ready,
  output reg [6:0] assign_addr,
  output reg [SW-1:0] assign_slot,
  input wire [7:0] assign_traits,
  output wire share_valid,
  input wire share_ready,
  output reg [6:0] share_addr,
  output reg [7:0] share_traits,
  input wire hj_req,
  input wire [SW-1:0] hj_slot,
  input wire dyn_addr_set,
  input wire [6:0] dyn_addr_in,
  input wire [MAX_DEV-1:0] ibi_req,
  output reg ibi_grant,
  output reg [SW-1:0] ibi_grant_slot,
  input wire frame_valid,
  input wire frame_legacy,
  input wire [6:0] frame_addr,
  output wire frame_respond,
  input wire hdr_enter_req,
  input wire exit_gen_req,
  input wire sda_in,
  input wire scl_in,
  output wire sda_out,
  output wire sda_oe_n,
  output wire scl_out,
  output wire scl_oe_n,
  output reg [7:0] bus_traits,
  output reg [6:0] own_addr,
  output reg own_addr_valid,
  output wire [4:0] bus_mode,
  output wire can_arbitrate,
  output wire can_hdr_access,
  output wire can_hdr_drive,
  output wire exit_busy
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ASSIGN = 5'h02;
  localparam [4:0] ST_SHARE = 5'h04;
  localparam [4:0] ST_SDR = 5'h08;
  localparam [4:0] ST_HDR = 5'h10;
  localparam integer LAST_INT = MAX_DEV - 1;
  localparam [SW-1:0] LAST = LAST_INT[SW-1:0];

  // ****************************************************************
  // Role capture and capability decode
  // ****************************************************************
  reg [2:0] role;
  reg role_taken;
  wire is_main;
  wire is_ctrl;
  wire is_full;

  // Strap is caught on the first clock after reset is released
  always @(posedge clk)
  begin
    if (reset)
    begin
      role <= `TBR_ROLE_TGT;
      role_taken <= 1'b0;
    end
    else if (!role_taken)
    begin
      role <= role_strap;
      role_taken <= 1'b1;
    end
  end

  assign is_main = (role == `TBR_ROLE_MAIN) || (role == `TBR_ROLE_SDR_MAIN);
  assign is_ctrl = is_main || (role == `TBR_ROLE_SEC) ||
    (role == `TBR_ROLE_SDR_SEC);
  assign is_full = (role == `TBR_ROLE_MAIN) || (role == `TBR_ROLE_SEC) ||
    (role == `TBR_ROLE_TGT);
  assign can_arbitrate = role_taken && is_ctrl;
  assign can_hdr_access = role_taken && is_full;
  assign can_hdr_drive = role_taken && is_full && is_ctrl;

  // Hot-join assignment: always for main, optional for secondary
  wire hj_allowed;
  assign hj_allowed = role_taken &&
    (is_main || (is_ctrl && hj_assign_en));

  always @(posedge clk)
  begin
    if (reset)
      bus_traits <= `TBR_BT_RESET;
    else
    begin
      bus_traits[`TBR_BT_ROLE_HI:`TBR_BT_ROLE_LO] <= is_ctrl ?
        `TBR_BT_ROLE_CTRL : `TBR_BT_ROLE_TGT;
      bus_traits[`TBR_BT_HDR] <= is_full;
      bus_traits[`TBR_BT_BRIDGE] <= BRIDGE;
      bus_traits[`TBR_BT_OFFLINE] <= OFFLINE;
      bus_traits[2:0] <= LOW_TRAITS;
    end
  end

  // ****************************************************************
  // Address allocation helper
  // ****************************************************************
  // Skips the legacy fixed address and the broadcast address
  function [6:0] adv;
    input [6:0] a;
    input [6:0] skip;
    reg [6:0] n;
    begin
      n = a + 7'h01;
      if (n == skip || n == `TBR_ADDR_BCAST)
        n = n + 7'h01;
      if (n == skip || n == `TBR_ADDR_BCAST)
        n = n + 7'h01;
      adv = n;
    end
  endfunction

  // ****************************************************************
  // Configuration state machine
  // ****************************************************************
  reg [4:0] state;
  reg [MAX_DEV-1:0] assigned;
  reg [6:0] addr_tab [0:MAX_DEV-1];
  reg [7:0] traits_tab [0:MAX_DEV-1];
  reg hj_pending;
  reg start_seen;
  reg [SW-1:0] share_slot;
  wire exit_seen;
  wire scan_slot_ok;

  assign bus_mode = state;
  assign scan_slot_ok = dev_present[assign_slot];
  assign assign_valid = ((state == ST_ASSIGN) && own_addr_valid &&
    scan_slot_ok) || ((state == ST_SDR) && hj_pending);
  assign share_valid = (state == ST_SHARE) && assigned[share_slot];

  always @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      assigned <= {MAX_DEV{1'b0}};
      own_addr <= `TBR_ADDR_RESET;
      own_addr_valid <= 1'b0;
      assign_addr <= `TBR_DYN_ADDR_BASE;
      assign_slot <= {SW{1'b0}};
      share_slot <= {SW{1'b0}};
      share_addr <= `TBR_ADDR_RESET;
      share_traits <= 8'h00;
      hj_pending <= 1'b0;
      start_seen <= 1'b0;
    end
    else
    begin
      if (bus_start)
        start_seen <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          // Main waits for legacy devices to be known first
          if (is_main && start_seen && legacy_known)
          begin
            state <= ST_ASSIGN;
            assign_addr <= `TBR_DYN_ADDR_BASE;
            assign_slot <= {SW{1'b0}};
            assigned <= {MAX_DEV{1'b0}};
          end
          else if (!is_main && role_taken && dyn_addr_set)
          begin
            own_addr <= dyn_addr_in;
            own_addr_valid <= 1'b1;
            state <= ST_SDR;
          end
        end
        ST_ASSIGN:
        begin
          if (!own_addr_valid)
          begin
            own_addr <= assign_addr;
            own_addr_valid <= 1'b1;
            assign_addr <= adv(assign_addr, legacy_addr);
          end
          else if (!scan_slot_ok || assign_ready)
          begin
            if (scan_slot_ok)
            begin
              addr_tab[assign_slot] <= assign_addr;
              traits_tab[assign_slot] <= assign_traits;
              assigned[assign_slot] <= 1'b1;
              assign_addr <= adv(assign_addr, legacy_addr);
            end
            if (assign_slot == LAST)
            begin
              share_slot <= {SW{1'b0}};
              share_addr <= addr_tab[0];
              share_traits <= traits_tab[0];
              state <= sec_present ? ST_SHARE : ST_SDR;
            end
            else
              assign_slot <= assign_slot + {{(SW-1){1'b0}}, 1'b1};
          end
        end
        ST_SHARE:
        begin
          if (!assigned[share_slot] || share_ready)
          begin
            if (share_slot == LAST)
              state <= ST_SDR;
            else
            begin
              share_slot <= share_slot + {{(SW-1){1'b0}}, 1'b1};
              share_addr <= addr_tab[share_slot + {{(SW-1){1'b0}}, 1'b1}];
              share_traits <=
                traits_tab[share_slot + {{(SW-1){1'b0}}, 1'b1}];
            end
          end
        end
        ST_SDR:
        begin
          if (hj_pending)
          begin
            if (assign_ready)
            begin
              addr_tab[assign_slot] <= assign_addr;
              traits_tab[assign_slot] <= assign_traits;
              assigned[assign_slot] <= 1'b1;
              assign_addr <= adv(assign_addr, legacy_addr);
              hj_pending <= 1'b0;
            end
          end
          else if (hj_req && hj_allowed)
          begin
            hj_pending <= 1'b1;
            assign_slot <= hj_slot;
          end
          else if (!is_main && dyn_addr_set)
            own_addr <= dyn_addr_in;
          else if (hdr_enter_req && is_full && own_addr_valid)
            state <= ST_HDR;
        end
        ST_HDR:
        begin
          if (exit_seen)
            state <= ST_SDR;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Interrupt arbitration by dynamic address
  // ****************************************************************
  wire [MAX_DEV-1:0] ibi_elig;
  genvar g;
  generate
    for (g = 0; g < MAX_DEV; g = g + 1)
    begin : g_elig
      assign ibi_elig[g] = ibi_req[g] && assigned[g];
    end
  endgenerate

  reg best_found;
  reg [SW-1:0] best_slot;
  reg [6:0] best_addr;
  integer i;

  // Lowest address wins; linear search is fine for a handful of slots
  always @*
  begin
    best_found = 1'b0;
    best_slot = {SW{1'b0}};
    best_addr = 7'h7F;
    for (i = 0; i < MAX_DEV; i = i + 1)
    begin
      if (ibi_elig[i] && (!best_found || addr_tab[i] < best_addr))
      begin
        best_found = 1'b1;
        best_slot = i[SW-1:0];
        best_addr = addr_tab[i];
      end
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      ibi_grant <= 1'b0;
      ibi_grant_slot <= {SW{1'b0}};
    end
    else
    begin
      ibi_grant <= can_arbitrate && (state == ST_SDR) &&
        best_found;
      if (best_found)
        ibi_grant_slot <= best_slot;
    end
  end

  // ****************************************************************
  // Frame filter for targets
  // ****************************************************************
  // Legacy frames never reach the target decode, even on address match
  assign frame_respond = frame_valid && !frame_legacy && own_addr_valid &&
    (state == ST_SDR) && (frame_addr == own_addr);

  // ****************************************************************
  // Exit pattern pins
  // ****************************************************************
  tbr_exit_pattern u_exit
  (
    .clk(clk),
    .reset(reset),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .gen_req(exit_gen_req && can_arbitrate),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .exit_seen(exit_seen),
    .gen_busy(exit_busy)
  );

endmodule // tbr_role_config

// [tbr_role_config_props.sv]
// Concurrent checks on the ports of the bus role configuration block
`timescale 1ns/10ps
module tbr_role_config_props
(
  input wire clk,
  input wire reset,
  input wire assign_valid,
  input wire assign_ready,
  input wire [6:0] assign_addr,
  input wire [6:0] legacy_addr,
  input wire [4:0] bus_mode,
  input wire [7:0] bus_traits,
  input wire own_addr_valid,
  input wire can_arbitrate,
  input wire can_hdr_access,
  input wire can_hdr_drive,
  input wire ibi_grant,
  input wire frame_valid,
  input wire frame_legacy,
  input wire frame_respond,
  input wire exit_busy,
  input wire sda_oe_n,
  input wire scl_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ******
  // Address offers
  // ******
  sequence s_offer_open;
    assign_valid && !assign_ready;
  endsequence
  property p_offer_hold;
    s_offer_open |=> assign_valid && $stable(assign_addr);
  endproperty
  a_offer_hold: assert property (p_offer_hold)
    else $error("address offer dropped or changed before accept");
  a_assign_legal: assert property (assign_valid |->
    can_arbitrate && assign_addr != legacy_addr && assign_addr != 7'h7E)
    else $error("address offer clashes or comes from a non-controller");

  // ******
  // Modes and role capabilities
  // ******
  a_mode_onehot: assert property ($onehot(bus_mode))
    else $error("bus mode not one-hot");
  a_hdr_entry: assert property ($rose(bus_mode[4]) |->
    $past(bus_mode[3]) && can_hdr_access)
    else $error("high-rate entered other than from single-rate");
  a_hdr_leave: assert property (bus_mode[4] |=>
    bus_mode[4] || bus_mode[3])
    else $error("high-rate left to a mode other than single-rate");
  a_role_caps: assert property (own_addr_valid |->
    can_arbitrate == (bus_traits[7:6] == 2'h1) &&
    can_hdr_drive == (bus_traits[7:5] == 3'h3))
    else $error("capabilities disagree with traits");
  a_ibi_grant: assert property (ibi_grant |->
    can_arbitrate && bus_mode == 5'h08)
    else $error("interrupt grant outside controller single-rate");
  a_legacy_quiet: assert property (frame_valid && frame_legacy |->
    !frame_respond)
    else $error("response to legacy traffic");
  a_exit_ctrl: assert property (exit_busy |-> can_arbitrate)
    else $error("exit pattern generated by a target");
  a_target_pins: assert property (!can_arbitrate |->
    sda_oe_n && scl_oe_n)
    else $error("target drives the bus pins");
endmodule // tbr_role_config_props

// [tbr_far_side.sv]
// Far-side model: targets answering offers, open-drain wires, exit pattern
`timescale 1ns/10ps
module tbr_far_side
(
  input wire clk,
  input wire assign_valid,
  input wire [2:0] assign_slot,
  output reg assign_ready,
  output reg [7:0] assign_traits,
  input wire share_valid,
  output reg share_ready,
  input wire sda_oe_n,
  input wire scl_oe_n,
  output wire sda_in,
  output wire scl_in,
  input wire pat_go
);
  reg sda_drv = 1'b1;
  reg scl_drv = 1'b1;
  integer wait_n = 0;
  initial
  begin
    assign_ready = 1'b0;
    share_ready = 1'b0;
    assign_traits = 8'h00;
  end
  // Pull-ups: any party pulling low wins the wire
  assign sda_in = sda_oe_n & sda_drv;
  assign scl_in = scl_oe_n & scl_drv;
  // Random stall of up to two cycles; traits only valid with ready
  always @(posedge clk)
  begin
    assign_ready <= 1'b0;
    share_ready <= 1'b0;
    assign_traits <= ~assign_traits;
    if ((assign_valid && !assign_ready) || (share_valid && !share_ready))
    begin
      if (wait_n == 0)
      begin
        assign_ready <= assign_valid;
        share_ready <= share_valid;
        assign_traits <= 8'h28 + assign_slot;
        wait_n = $urandom_range(2);
      end
      else
        wait_n = wait_n - 1;
    end
  end
  // Exit pattern: four data falls with the clock line held low
  initial forever
  begin
    @(posedge clk);
    if (pat_go)
    begin
      scl_drv <= 1'b0;
      repeat (4)
      begin
        repeat (3) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (3) @(posedge clk);
        sda_drv <= 1'b1;
      end
      repeat (3) @(posedge clk);
      scl_drv <= 1'b1;
    end
  end
endmodule // tbr_far_side

// [tbr_role_config_bench.sv]
// Self-checking bench for the bus role configuration block
`timescale 1ns/10ps
module tbr_role_config_bench;
  reg clk, reset = 1'b1, hj_assign_en = 1'b0, bus_start = 1'b0;
  reg legacy_known = 1'b0, sec_present = 1'b0, hj_req = 1'b0, pat_go = 1'b0;
  reg dyn_addr_set = 1'b0, frame_valid = 1'b0, frame_legacy = 1'b0;
  reg hdr_enter_req = 1'b0, exit_gen_req = 1'b0;
  reg [2:0] role_strap = 3'h0, hj_slot = 3'h0;
  reg [6:0] legacy_addr = 7'h09, dyn_addr_in = 7'h00, frame_addr = 7'h00;
  reg [7:0] dev_present = 8'h00, ibi_req = 8'h00;
  wire assign_valid, assign_ready, share_valid, share_ready, ibi_grant;
  wire frame_respond, sda_in, scl_in, sda_out, sda_oe_n, scl_out, scl_oe_n;
  wire own_addr_valid, can_arbitrate, can_hdr_access, can_hdr_drive, exit_busy;
  wire [6:0] assign_addr, share_addr, own_addr;
  wire [2:0] assign_slot, ibi_grant_slot;
  wire [7:0] assign_traits, share_traits, bus_traits;
  wire [4:0] bus_mode;
  logic [15:0] q_asg[$];
  logic [15:0] q_shr[$];
  integer fails = 0, n_checks = 0, r, seed;

  tbr_role_config uut (.clk(clk), .reset(reset), .role_strap(role_strap),
    .hj_assign_en(hj_assign_en), .bus_start(bus_start),
    .legacy_known(legacy_known), .legacy_addr(legacy_addr),
    .dev_present(dev_present), .sec_present(sec_present),
    .assign_valid(assign_valid), .assign_ready(assign_ready),
    .assign_addr(assign_addr), .assign_slot(assign_slot),
    .assign_traits(assign_traits), .share_valid(share_valid),
    .share_ready(share_ready), .share_addr(share_addr),
    .share_traits(share_traits), .hj_req(hj_req), .hj_slot(hj_slot),
    .dyn_addr_set(dyn_addr_set), .dyn_addr_in(dyn_addr_in),
    .ibi_req(ibi_req), .ibi_grant(ibi_grant),
    .ibi_grant_slot(ibi_grant_slot), .frame_valid(frame_valid),
    .frame_legacy(frame_legacy), .frame_addr(frame_addr),
    .frame_respond(frame_respond), .hdr_enter_req(hdr_enter_req),
    .exit_gen_req(exit_gen_req), .sda_in(sda_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .bus_traits(bus_traits), .own_addr(own_addr),
    .own_addr_valid(own_addr_valid), .bus_mode(bus_mode),
    .can_arbitrate(can_arbitrate), .can_hdr_access(can_hdr_access),
    .can_hdr_drive(can_hdr_drive), .exit_busy(exit_busy));

  tbr_far_side far (.clk(clk), .assign_valid(assign_valid),
    .assign_slot(assign_slot), .assign_ready(assign_ready),
    .assign_traits(assign_traits), .share_valid(share_valid),
    .share_ready(share_ready), .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
    .sda_in(sda_in), .scl_in(scl_in), .pat_go(pat_go));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task test_done;
  begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  // Every accepted offer and share is matched against the model queues
  always @(posedge clk)
  begin
    if (assign_valid === 1'b1 && assign_ready === 1'b1)
      chk("assign", q_asg.pop_front(), {assign_slot, assign_addr});
    if (share_valid === 1'b1 && share_ready === 1'b1)
      chk("share", q_shr.pop_front(), {share_traits, share_addr});
  end

  task pulse_wait(input integer n);
  begin
    @(posedge clk);
    bus_start <= 1'b0;
    dyn_addr_set <= 1'b0;
    hj_req <= 1'b0;
    hdr_enter_req <= 1'b0;
    exit_gen_req <= 1'b0;
    pat_go <= 1'b0;
    repeat (n) @(negedge clk);
  end
  endtask

  task run_role(input [2:0] rl);
    reg ctrl, full, prev;
    integer i, n, nxt, slot;
  begin
    ctrl = rl < 3'h4;
    full = rl == 3'h0 || rl == 3'h1 || rl == 3'h4;
    @(posedge clk);
    reset <= 1'b1;
    role_strap <= rl;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    chk("traits", {ctrl, full, 5'h00}, bus_traits);
    chk("caps", {ctrl, full, full & ctrl},
      {can_arbitrate, can_hdr_access, can_hdr_drive});
    chk("mode", 5'h01, bus_mode);
    @(posedge clk);
    exit_gen_req <= 1'b1;
    pulse_wait(0);
    @(negedge clk);
    chk("exit_busy", ctrl, exit_busy);
    chk("drive_lvl", 0, {sda_out, scl_out});
    n = 0;
    prev = 1'b1;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(negedge clk);
      if (prev === 1'b1 && sda_oe_n === 1'b0)
        n = n + 1;
      prev = sda_oe_n;
    end
    chk("exit_lows", ctrl ? 4 : 0, n);
    @(posedge clk);
    legacy_known <= 1'b0;
    bus_start <= 1'b1;
    legacy_addr <= 7'h09 + 7'($urandom_range(5));
    dev_present <= (8'($urandom) & 8'h7F) | 8'h01;
    sec_present <= rl == 3'h0;
    hj_assign_en <= rl == 3'h1;
    dyn_addr_set <= !(rl == 3'h0 || rl == 3'h2);
    dyn_addr_in <= 7'h30 + rl;
    pulse_wait(5);
    nxt = 9;
    if (rl == 3'h0 || rl == 3'h2)
    begin
      chk("wait_legacy", 5'h01, bus_mode);
      for (slot = 0; slot < 8; slot = slot + 1)
        if (dev_present[slot])
        begin
          while (nxt == legacy_addr)
            nxt = nxt + 1;
          q_asg.push_back(16'(slot * 128 + nxt));
          if (sec_present)
            q_shr.push_back(16'((8'h28 + slot) * 128 + nxt));
          nxt = nxt + 1;
        end
      @(posedge clk);
      legacy_known <= 1'b1;
      for (i = 0; i < 300 && bus_mode !== 5'h08; i = i + 1)
        @(negedge clk);
      chk("own_addr", 8'h88, {own_addr_valid, own_addr});
      chk("left", 0, q_asg.size() + q_shr.size());
      while (nxt == legacy_addr)
        nxt = nxt + 1;
      q_asg.push_back(16'(7 * 128 + nxt));
    end
    else
      chk("own_addr", 8'hB0 + rl, {own_addr_valid, own_addr});
    // Secondary with optional hot-join offers from the base address
    if (rl == 3'h1)
      q_asg.push_back(16'h0388);
    @(posedge clk);
    hj_slot <= 3'h7;
    hj_req <= 1'b1;
    pulse_wait(10);
    chk("hot_join", 0, q_asg.size());
    chk("sdr", 5'h08, bus_mode);
    @(posedge clk);
    ibi_req <= (8'($urandom) & dev_present) | 8'h80;
    repeat (2) @(negedge clk);
    for (slot = 7; slot >= 0; slot = slot - 1)
      if (ibi_req[slot])
        n = slot;
    chk("ibi", (rl == 3'h0 || rl == 3'h2) ? 8 + n : (rl == 3'h1 ? 15 : 0),
      {ibi_grant, ibi_grant_slot});
    @(posedge clk);
    ibi_req <= 8'h00;
    frame_valid <= 1'b1;
    frame_legacy <= 1'b0;
    frame_addr <= own_addr;
    @(negedge clk);
    chk("respond", 1, frame_respond);
    @(posedge clk);
    frame_legacy <= 1'b1;
    @(negedge clk);
    chk("legacy_quiet", 0, frame_respond);
    @(posedge clk);
    frame_valid <= 1'b0;
    hdr_enter_req <= 1'b1;
    pulse_wait(2);
    chk("hdr", full ? 5'h10 : 5'h08, bus_mode);
    @(posedge clk);
    pat_go <= 1'b1;
    pulse_wait(40);
    chk("hdr_exit", 5'h08, bus_mode);
  end
  endtask

  initial
  begin
    seed = $urandom(32'h427cc151);
    for (r = 0; r < 6; r = r + 1)
      run_role(r[2:0]);
    test_done;
  end

  // Six role passes of one to two hundred cycles each
  initial
  begin
    repeat (6000) @(posedge clk);
    fails = fails + 1;
    test_done;
  end
endmodule // tbr_role_config_bench

bind tbr_role_config tbr_role_config_props u_props (.clk(clk), .reset(reset),
  .assign_valid(assign_valid), .assign_ready(assign_ready),
  .assign_addr(assign_addr), .legacy_addr(legacy_addr), .bus_mode(bus_mode),
  .bus_traits(bus_traits), .own_addr_valid(own_addr_valid),
  .can_arbitrate(can_arbitrate), .can_hdr_access(can_hdr_access),
  .can_hdr_drive(can_hdr_drive), .ibi_grant(ibi_grant),
  .frame_valid(frame_valid), .frame_legacy(frame_legacy),
  .frame_respond(frame_respond), .exit_busy(exit_busy),
  .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n));
